// ---- shared/crcu_cfg.svh ----
// Constants for the checksum engine
`ifndef CRCU_CFG_SVH
`define CRCU_CFG_SVH
`define CRCU_POLY16 16'h8005
`define CRCU_POLYCCITT 16'h1021
`define CRCU_POLY32 32'h04C1_1DB7
`define CRCU_SEED_RST 32'h0000_0000
`define CRCU_CYC_BYTE 1
`define CRCU_CYC_WORD 4
`endif

// ---- shared/crcu_pkg.sv ----
// Types for the checksum engine
`default_nettype none
package crcu_pkg;
  typedef enum logic [1:0] {
    CRCU_MODE_16 = 2'b00,
    CRCU_MODE_CCITT = 2'b01,
    CRCU_MODE_32 = 2'b10
  } crcu_mode_e;
  typedef enum logic [1:0] {
    CRCU_SZ_BYTE = 2'b00,
    CRCU_SZ_HALF = 2'b01,
    CRCU_SZ_WORD = 2'b10
  } crcu_size_e;
  typedef struct packed {
    crcu_mode_e mode;
    logic dataCompl;
    logic dataByteRev;
    logic dataBitRev;
    logic sumCompl;
    logic sumByteRev;
    logic sumBitRev;
  } crcu_cfg_s;
  typedef struct packed {
    logic [31:0] data;
    crcu_size_e size;
  } crcu_wr_s;
  typedef enum logic [1:0] {
    CRCU_ST_IDLE = 2'b01,
    CRCU_ST_BUSY = 2'b10
  } crcu_state_e;
endpackage
`default_nettype wire

// ---- rtl/crcu_engine.sv ----
// Checksum engine: folds byte, half-word or word writes into a CRC
//
// Notes on behaviour
// - A 16-bit mode uses generator 0x8005.
// - A second 16-bit mode uses the CCITT generator 0x1021.
// - A 32-bit mode uses generator 0x04C11DB7.
// - Complement, byte reversal and bit reversal apply to data and sum.
// - Writes are 8, 16 or 32 bits and only their bytes are folded.
// - Software loads any seed from which accumulation starts.
// - One byte write is folded in a single clock cycle.
// - One word write is folded within four clock cycles.
// - The write port takes data from the DMA controller as from the core.
// - The result is 16 bits wide in 16-bit modes and 32 in 32-bit mode.
`include "crcu_cfg.svh"
`default_nettype none
module crcu_engine
  import crcu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire crcu_cfg_s cfg,
  input wire logic seedLoad,
  input wire logic [31:0] seedValue,
  input wire logic wrValid,
  input wire crcu_wr_s wrData,
  output logic wrReady,
  output logic [31:0] checksum,
  output logic busy
);
  crcu_state_e state_q;
  logic [31:0] crc_q;
  logic [31:0] shift_q;
  logic [1:0] left_q;
  logic [31:0] raw;
  logic [31:0] dataIn;
  logic [31:0] crcOne;
  logic [31:0] res;
  logic [1:0] nBytes;
  logic wrTake;

  // Bit reversal within each byte, a byte swap over the written size
  function automatic logic [31:0] prep(input logic [31:0] d,
                                       input crcu_cfg_s c,
                                       input crcu_size_e s);
    logic [31:0] r;
    logic [31:0] q;
    r = c.dataCompl ? ~d : d;
    if (c.dataByteRev) begin
      unique case (s)
        CRCU_SZ_HALF: r = {16'h0000, r[7:0], r[15:8]};
        CRCU_SZ_WORD: r = {r[7:0], r[15:8], r[23:16], r[31:24]};
        default: r = r;
      endcase
    end
    // Mirror from a copy; reversing in place would undo half the swaps
    q = r;
    if (c.dataBitRev) begin
      for (int b = 0; b < 32; b++) begin
        r[b] = q[(b & ~7) + 7 - (b % 8)];
      end
    end
    return r;
  endfunction

  // One byte folded through the selected generator, MSB first
  function automatic logic [31:0] foldByte(input logic [31:0] c,
                                           input logic [7:0] d,
                                           input crcu_mode_e m);
    logic [31:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      if (m == CRCU_MODE_32) begin
        x = x[31] ^ d[i] ? ((x << 1) ^ `CRCU_POLY32) : (x << 1);
      end else if (m == CRCU_MODE_CCITT) begin
        x = {16'h0000, (x[15] ^ d[i]) ?
             (x[15:0] << 1) ^ `CRCU_POLYCCITT : (x[15:0] << 1)};
      end else begin
        x = {16'h0000, (x[15] ^ d[i]) ?
             (x[15:0] << 1) ^ `CRCU_POLY16 : (x[15:0] << 1)};
      end
    end
    return x;
  endfunction

  // Bit-reversal of a byte mirrors bits inside the byte, so lane order holds
  always_comb begin
    raw = wrData.data;
    dataIn = prep(raw, cfg, wrData.size);
  end

  // A byte write finishes at once; larger writes walk one byte per cycle
  assign nBytes = (wrData.size == CRCU_SZ_WORD) ? 2'd3 :
                  (wrData.size == CRCU_SZ_HALF) ? 2'd1 : 2'd0;
  assign wrTake = wrValid && wrReady;

  always_comb begin
    if (state_q == CRCU_ST_IDLE) begin
      unique case (wrData.size)
        CRCU_SZ_WORD: crcOne = foldByte(crc_q, dataIn[31:24], cfg.mode);
        CRCU_SZ_HALF: crcOne = foldByte(crc_q, dataIn[15:8], cfg.mode);
        default: crcOne = foldByte(crc_q, dataIn[7:0], cfg.mode);
      endcase
    end else begin
      crcOne = foldByte(crc_q, shift_q[31:24], cfg.mode);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= CRCU_ST_IDLE;
      left_q <= 2'd0;
      shift_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        CRCU_ST_IDLE: begin
          if (wrTake && nBytes != 2'd0) begin
            state_q <= CRCU_ST_BUSY;
            left_q <= nBytes;
            shift_q <= (wrData.size == CRCU_SZ_WORD) ? dataIn << 8 :
                       {dataIn[7:0], 24'h00_0000};
          end
        end
        CRCU_ST_BUSY: begin
          shift_q <= shift_q << 8;
          left_q <= left_q - 2'd1;
          if (left_q == 2'd1) begin
            state_q <= CRCU_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Seed load wins over folding; software should load while idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crc_q <= `CRCU_SEED_RST;
    end else if (seedLoad) begin
      crc_q <= (cfg.mode == CRCU_MODE_32) ? seedValue :
               {16'h0000, seedValue[15:0]};
    end else if (wrTake || state_q == CRCU_ST_BUSY) begin
      crc_q <= crcOne;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrReady <= 1'b1;
      busy <= 1'b0;
    end else begin
      wrReady <= !((wrTake && nBytes != 2'd0) ||
                   (state_q == CRCU_ST_BUSY && left_q != 2'd1));
      busy <= (wrTake && nBytes != 2'd0) ||
              (state_q == CRCU_ST_BUSY && left_q != 2'd1);
    end
  end

  // Output post-processing over the width of the active mode
  always_comb begin
    res = cfg.sumCompl ? ~crc_q : crc_q;
    if (cfg.mode != CRCU_MODE_32) begin
      res[31:16] = 16'h0000;
    end
    if (cfg.sumByteRev) begin
      res = (cfg.mode == CRCU_MODE_32) ?
            {res[7:0], res[15:8], res[23:16], res[31:24]} :
            {16'h0000, res[7:0], res[15:8]};
    end
    if (cfg.sumBitRev) begin
      res = {<<{res}};
      if (cfg.mode != CRCU_MODE_32) begin
        res = {16'h0000, res[31:16]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      checksum <= 32'h0000_0000;
    end else begin
      checksum <= res;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/crcu_monitor.sv ----
// Port checker for the checksum engine
`default_nettype none
module crcu_monitor
  import crcu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire crcu_cfg_s cfg,
  input wire logic seedLoad,
  input wire logic [31:0] seedValue,
  input wire logic wrValid,
  input wire crcu_wr_s wrData,
  input wire logic wrReady,
  input wire logic [31:0] checksum,
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic tk = wrValid && wrReady;
  wire logic [1:0] sz = wrData.size;
  sequence hold3_s; !wrReady [*3] ##1 wrReady; endsequence
  sequence seed_s;
    seedLoad && !busy && !wrValid && cfg == {CRCU_MODE_32, 6'h00}
    ##1 !wrValid;
  endsequence
  byte_ready_a: assert property (
    tk && sz == CRCU_SZ_BYTE |=> wrReady) else $error("byte");
  half_hold_a: assert property (
    tk && sz == CRCU_SZ_HALF |=> !wrReady ##1 wrReady) else $error("half");
  word_hold_a: assert property (
    tk && sz == CRCU_SZ_WORD |=> hold3_s) else $error("word");
  word_busy_a: assert property (
    tk && sz == CRCU_SZ_WORD |=> busy [*3] ##1 !busy) else $error("busy");
  narrow_sum_a: assert property (
    tk && cfg.mode != CRCU_MODE_32 |-> ##2 checksum[31:16] == 16'h0000)
    else $error("width");
  seed_load_a: assert property (
    seed_s |=> checksum == $past(seedValue, 2)) else $error("seed");
  busy_block_a: assert property (
    busy |-> !wrReady) else $error("ready");
  ready_drop_a: assert property (
    $fell(wrReady) |-> $past(tk)) else $error("drop");
endmodule
bind crcu_engine crcu_monitor crcu_monitor_inst (.*);
`default_nettype wire

// ---- testbench/crcu_dma_model.sv ----
// Bus master model feeding writes to the checksum engine
`default_nettype none
module crcu_dma_model
  import crcu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wrReady,
  output logic wrValid,
  output crcu_wr_s wrData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wrValid = 1'b0;
    wrData = '0;
  end
  task automatic send(crcu_wr_s w);
    @(negedge ref_clk);
    wrValid = 1'b1;
    wrData = w;
    while (!wrReady) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask
  // Released data is inverted so a stale value never passes as valid
  task automatic idle();
    @(negedge ref_clk);
    wrValid = 1'b0;
    wrData.data = ~wrData.data;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Bench for the checksum engine
`default_nettype none
module tb_top
  import crcu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  crcu_cfg_s cfg = '0;
  logic seedLoad = 1'b0;
  logic [31:0] seedValue = '0;
  logic wrValid, wrReady, busy;
  crcu_wr_s wrData;
  logic [31:0] checksum, e, t0;
  int errors = 0;
  int tests_run = 0;
  typedef struct {crcu_mode_e m; crcu_wr_s w; logic [31:0] s;} crcu_row_s;
  crcu_row_s rows [4] = '{
    '{CRCU_MODE_16, '{32'h1234_56A5, CRCU_SZ_BYTE}, 32'h0000_FFFF},
    '{CRCU_MODE_CCITT, '{32'hFFFF_1D0F, CRCU_SZ_HALF}, 32'h0000_FFFF},
    '{CRCU_MODE_32, '{32'h1234_5678, CRCU_SZ_WORD}, 32'hFFFF_FFFF},
    '{CRCU_MODE_16, '{32'hDEAD_BEEF, CRCU_SZ_WORD}, 32'h0000_0000}};
  crcu_wr_s b = '{32'h0000_00C3, CRCU_SZ_BYTE};
  crcu_engine crcu_engine_inst (.*);
  crcu_dma_model crcu_dma_model_inst (.*);
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] fold(logic [31:0] c, crcu_wr_s w,
      crcu_mode_e m);
    int t = m == CRCU_MODE_32 ? 31 : 15;
    logic [31:0] p = m == CRCU_MODE_32 ? 32'h04C1_1DB7 :
      m == CRCU_MODE_16 ? 32'h0000_8005 : 32'h0000_1021;
    for (int i = 8 << w.size; i > 0; i--)
      c = (c << 1) ^ ((c[t] ^ w.data[i - 1]) ? p : 32'h0000_0000);
    return m == CRCU_MODE_32 ? c : c & 32'h0000_FFFF;
  endfunction
  task automatic chk(logic [31:0] got);
    tests_run++;
    if (got !== e) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, e);
    end
  endtask
  task automatic run(crcu_mode_e m, logic [5:0] f, logic [31:0] s,
      crcu_wr_s w);
    @(negedge ref_clk);
    cfg = {m, f};
    seedLoad = 1'b1;
    seedValue = s;
    @(negedge ref_clk);
    seedLoad = 1'b0;
    crcu_dma_model_inst.send(w);
    crcu_dma_model_inst.send(w);
    crcu_dma_model_inst.idle();
    repeat (6) @(negedge ref_clk);
    chk(checksum);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20us;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    e = 32'h0000_0000;
    chk(checksum); // see RESET
    foreach (rows[k]) begin
      e = fold(fold(rows[k].s, rows[k].w, rows[k].m), rows[k].w, rows[k].m);
      run(rows[k].m, 6'h00, rows[k].s, rows[k].w);
    end
    // Complemented data in, complemented sum out
    e = ~fold(fold(32'h0000_0000, b, CRCU_MODE_32), b, CRCU_MODE_32);
    b.data = 32'h0000_003C;
    run(CRCU_MODE_32, 6'h24, 32'h0000_0000, b);
    // Byte swap of a half-word in, 16-bit byte swap of the sum out
    b = '{32'h0000_3412, CRCU_SZ_HALF};
    t0 = fold(fold(32'h0000_FFFF, b, CRCU_MODE_16), b, CRCU_MODE_16);
    e = {16'h0000, t0[7:0], t0[15:8]};
    b.data = 32'h0000_1234;
    run(CRCU_MODE_16, 6'h12, 32'h0000_FFFF, b);
    // Bit mirror inside the byte in, full-width bit mirror out
    b = '{32'h0000_0080, CRCU_SZ_BYTE};
    t0 = fold(fold(32'h0000_0000, b, CRCU_MODE_32), b, CRCU_MODE_32);
    e = {<<{t0}};
    b.data = 32'h0000_0001;
    run(CRCU_MODE_32, 6'h09, 32'h0000_0000, b);
    tally_and_finish();
  end
endmodule
`default_nettype wire
